// ==== rtl/iopdw_pkg.sv ====
// package: constants and carrier structs for the i/o port decode and wait glue
package iopdw_pkg;

  // port offsets within the eight-port window
  localparam logic [2:0] PORT_SER_DATA_A  = 3'h0;
  localparam logic [2:0] PORT_SER_CTRL_A  = 3'h1;
  localparam logic [2:0] PORT_SER_DATA_B  = 3'h2;
  localparam logic [2:0] PORT_SER_CTRL_B  = 3'h3;
  localparam logic [2:0] PORT_BANK_SEL    = 3'h4;
  localparam logic [2:0] PORT_CLK_INDEX   = 3'h5;
  localparam logic [2:0] PORT_CLK_DATA    = 3'h6;
  localparam logic [2:0] PORT_SWITCH      = 3'h7;

  // address field layout
  localparam int PORT_BITS     = 3;
  localparam int ADDR_BITS     = 16;
  localparam int SHORT_BITS    = 8;
  localparam int SW_SHORT_BITS = 5;  // switches compared in 8-bit mode
  localparam int SW_LONG_BITS  = 13; // switches compared in 16-bit mode

  // clock index register layout
  localparam int CLK_IDX_BITS  = 5;
  localparam int BANK_BITS     = 2;
  localparam int BANK_LSB      = 6;

  // wait states
  localparam logic [2:0] WAIT_SERIAL = 3'h2;
  localparam logic [2:0] WAIT_CLOCK  = 3'h4;
  localparam logic [2:0] WAIT_NONE   = 3'h0;

  // reset values
  localparam logic [1:0] BANK_RST    = 2'h0;
  localparam logic [4:0] CLK_IDX_RST = 5'h00;

  // interrupt routing: 0..7 vectored, 8 non-maskable
  localparam int IRQ_LINES = 9;

  // bus request from the host side
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rd;   // i/o read strobe
    logic        wr;   // i/o write strobe
  } iopdw_req_type;

  // strobes toward the peripherals
  typedef struct packed {
    logic [3:0]  ser_cs;   // one per serial controller
    logic [1:0]  ser_reg;  // register within controller
    logic        clk_cs;
    logic [4:0]  clk_idx;
  } iopdw_sel_type;

endpackage

// ==== rtl/iopdw_glue.sv ====
// i/o port decode, bank select and wait generation glue for the serial/clock board
`timescale 1ns/100ps
module iopdw_glue
  import iopdw_pkg::*;
(
  // clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 sys_rst_i,
  // host bus
  input  wire iopdw_req_type        bus_req_i,
  output logic [7:0]                bus_rdata_o,
  output logic                      bus_rdata_oe_o,
  output logic                      bus_ready_o,
  // configuration straps
  input  wire logic [12:0]          base_sw_i,
  input  wire logic                 long_addr_i,
  input  wire logic [7:0]           user_sw_i,
  // peripheral side
  output iopdw_sel_type             per_sel_o,
  output logic                      per_rd_o,
  output logic                      per_wr_o,
  output logic [7:0]                per_wdata_o,
  input  wire logic [7:0]           per_rdata_i,
  // interrupts
  input  wire logic [7:0]           ser_irq_i,
  input  wire logic                 clk_stby_irq_i,
  input  wire logic                 clk_gen_irq_i,
  input  wire logic [3:0]           ser_irq_route_i,
  input  wire logic [3:0]           stby_irq_route_i,
  input  wire logic [3:0]           gen_irq_route_i,
  output logic [IRQ_LINES-1:0]      bus_irq_o
);

  // user switches are off-board pins: three-flop sampling
  // the first stage may go metastable, so only the second stage reads it
  logic [7:0] sw_s1_r, sw_s2_r, sw_s3_r, sw_val_r;
  // control state
  logic [1:0] bank_r;                   // selected serial controller
  logic [4:0] clk_idx_r;                // selected clock register
  logic [2:0] wait_cnt_r;               // wait states left
  logic       busy_r;                   // access in progress
  logic       ready_r;
  logic [7:0] rdata_r;
  logic       rdata_oe_r;
  iopdw_sel_type sel_r;
  // registered copies of the peripheral strobes
  logic       per_rd_r, per_wr_r;
  logic [7:0] per_wdata_r;
  // routed interrupt lines, one per bus line
  logic [IRQ_LINES-1:0] irq_r;

  // elaboration checks: the decode and routing logic serve only these layouts
  // the long compare must cover every address bit above the port field
  if (SW_LONG_BITS != ADDR_BITS - PORT_BITS) begin : g_chk_long
    $error("long compare width does not match the address field");
  end
  // the short compare must cover the byte address above the port field
  if (SW_SHORT_BITS != SHORT_BITS - PORT_BITS) begin : g_chk_short
    $error("short compare width does not match the address field");
  end
  // every bus interrupt line must have a route code
  if (IRQ_LINES > 2 ** $bits(ser_irq_route_i)) begin : g_chk_irq
    $error("route code too narrow for the interrupt lines");
  end
  // waited ports need a count: the counter stops on one, never on zero
  if (WAIT_SERIAL == WAIT_NONE || WAIT_CLOCK == WAIT_NONE) begin : g_chk_wait
    $error("waited ports need a nonzero wait count");
  end

  // board decode: compare upper address bits to switches
  // base switches and the mode jumper are read raw: they are static straps
  // and must only change while the board is held in reset
  wire logic short_hit = (bus_req_i.addr[SHORT_BITS-1:PORT_BITS] == base_sw_i[SW_SHORT_BITS-1:0]);
  wire logic long_hit  = (bus_req_i.addr[ADDR_BITS-1:PORT_BITS] == base_sw_i[SW_LONG_BITS-1:0]);
  wire logic board_sel = long_addr_i ? long_hit : short_hit;
  wire logic [2:0] port = bus_req_i.addr[PORT_BITS-1:0];
  wire logic access    = board_sel & (bus_req_i.rd | bus_req_i.wr) & ~busy_r;
  wire logic is_serial = (port[2] == 1'b0);
  wire logic is_clk    = (port == PORT_CLK_DATA);
  // wait count chosen by target
  // the select, index and switch ports answer in the same cycle
  wire logic [2:0] wait_need = is_serial ? WAIT_SERIAL :
                               is_clk    ? WAIT_CLOCK  : WAIT_NONE;
  // register read mux
  wire logic [7:0] idx_rd = {bank_r, 1'b0, clk_idx_r};
  wire logic [7:0] reg_rd = (port == PORT_CLK_INDEX) ? idx_rd :
                            (port == PORT_SWITCH)    ? sw_val_r : 8'h00;
  // active peripheral strobe only for waited accesses, none for fast ports
  // one-hot from the bank number: only one controller is ever selected
  wire logic [3:0] bank_dec = 4'h1 << bank_r;

  // switch synchroniser: update once second and third stages agree
  always_ff @(posedge core_clk_i) begin
    sw_s1_r <= user_sw_i;
    sw_s2_r <= sw_s1_r;
    sw_s3_r <= sw_s2_r;
    if (sys_rst_i) begin
      // reset: report all switches off until a stable value arrives
      sw_val_r <= 8'h00;
    end else if (sw_s2_r == sw_s3_r) begin
      // two stages agree: a half-settled sample never gets through
      sw_val_r <= sw_s3_r;
    end
  end

  // internal registers written by host
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      bank_r    <= BANK_RST;
      clk_idx_r <= CLK_IDX_RST;
    end else if (access && bus_req_i.wr) begin
      // misses and strobes held past the first edge never get here
      // bank write: only the low two data bits name a controller
      if (port == PORT_BANK_SEL) begin
        bank_r <= bus_req_i.wdata[BANK_BITS-1:0];
      end
      // index write: five bits, so register numbers wrap at the field width
      if (port == PORT_CLK_INDEX) begin
        clk_idx_r <= bus_req_i.wdata[CLK_IDX_BITS-1:0];
      end
    end
  end

  // access sequencer: ready low for the wait count, then data and ready
  // busy stays set until the host drops both strobes, so a held strobe is one access
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      // idle bus: ready high, so a quiet board never stalls the host
      busy_r      <= 1'b0;
      wait_cnt_r  <= WAIT_NONE;
      ready_r     <= 1'b1;
      rdata_r     <= 8'h00;
      rdata_oe_r  <= 1'b0;
      sel_r       <= '0;
      per_rd_r    <= 1'b0;
      per_wr_r    <= 1'b0;
      per_wdata_r <= 8'h00;
    end else if (access) begin
      // new access: peripheral strobes start, waits counted in bus clocks
      sel_r.ser_cs  <= is_serial ? bank_dec : 4'h0;
      sel_r.ser_reg <= port[1:0];
      sel_r.clk_cs  <= is_clk;
      sel_r.clk_idx <= clk_idx_r;
      per_rd_r      <= bus_req_i.rd & (wait_need != WAIT_NONE);
      per_wr_r      <= bus_req_i.wr & (wait_need != WAIT_NONE);
      per_wdata_r   <= bus_req_i.wdata;
      rdata_oe_r    <= bus_req_i.rd;
      if (wait_need == WAIT_NONE) begin
        // fast port: answer at once, ready never drops
        rdata_r <= reg_rd;
        busy_r  <= 1'b1;
        ready_r <= 1'b1;
      end else begin
        // slow port: hold ready low for the counted bus clocks
        busy_r     <= 1'b1;
        wait_cnt_r <= wait_need;
        ready_r    <= 1'b0;
      end
    end else if (busy_r && !ready_r) begin
      // peripheral data sampled on the last wait cycle
      wait_cnt_r <= wait_cnt_r - 3'h1;
      if (wait_cnt_r == 3'h1) begin
        // ready rises now; the host closes the cycle by dropping its strobe
        ready_r <= 1'b1;
        rdata_r <= per_rdata_i;
      end
    end else if (busy_r && !(bus_req_i.rd | bus_req_i.wr)) begin
      // strobes dropped: end of cycle, release bus data
      busy_r     <= 1'b0;
      rdata_oe_r <= 1'b0;
      sel_r      <= '0;
      per_rd_r   <= 1'b0;
      per_wr_r   <= 1'b0;
    end
  end

  // interrupt routing through jumpers; serial channels wire-ored
  // route codes above the non-maskable line leave that source unrouted
  wire logic ser_any = |ser_irq_i;
  logic [IRQ_LINES-1:0] irq_nxt;
  genvar gi;
  generate
    for (gi = 0; gi < IRQ_LINES; gi++) begin : g_irq
      assign irq_nxt[gi] = (ser_any        && ser_irq_route_i  == 4'(gi)) |
                           (clk_stby_irq_i && stby_irq_route_i == 4'(gi)) |
                           (clk_gen_irq_i  && gen_irq_route_i  == 4'(gi));
    end
  endgenerate

  // register the routed lines so outputs come from flops
  // one cycle of latency: a jumper or source change shows a cycle late
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      irq_r <= '0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // outputs
  // every one is a flop, so no decode glitch reaches the bus
  assign bus_rdata_o    = rdata_r;
  assign bus_rdata_oe_o = rdata_oe_r;
  assign bus_ready_o    = ready_r;
  assign per_sel_o      = sel_r;
  assign per_rd_o       = per_rd_r;
  assign per_wr_o       = per_wr_r;
  assign per_wdata_o    = per_wdata_r;
  assign bus_irq_o      = irq_r;

endmodule

// ==== dv/iopdw_monitor.sv ====
// checker: wait counts, selects and data drive of the glue
`timescale 1ns/100ps
module iopdw_monitor import iopdw_pkg::*; (
  input wire logic core_clk_i, sys_rst_i, long_addr_i, bus_ready_o, bus_rdata_oe_o, per_rd_o, per_wr_o,
  input wire logic [12:0] base_sw_i,
  input wire iopdw_req_type bus_req_i,
  input wire iopdw_sel_type per_sel_o
);
  logic stb_r; // strobe one cycle ago: a new access is its rising edge
  wire [2:0] p = bus_req_i.addr[2:0];
  wire hit = long_addr_i ? bus_req_i.addr[15:3] == base_sw_i : bus_req_i.addr[7:3] == base_sw_i[4:0];
  wire st = (bus_req_i.rd | bus_req_i.wr) & ~stb_r & hit;
  always_ff @(posedge core_clk_i) stb_r <= bus_req_i.rd | bus_req_i.wr;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_serial_two_waits: assert property (st && !p[2] |=> !bus_ready_o [*2] ##1 bus_ready_o)
    else $error("serial waits");
  a_clock_four_waits: assert property (st && p == PORT_CLK_DATA |=> !bus_ready_o [*4] ##1 bus_ready_o)
    else $error("clock waits");
  a_fast_no_wait: assert property (st && p[2] && p != PORT_CLK_DATA |=> bus_ready_o && !per_rd_o && !per_wr_o)
    else $error("fast port waited");
  a_miss_ignored: assert property ((bus_req_i.rd | bus_req_i.wr) && !hit |=> bus_ready_o && !bus_rdata_oe_o)
    else $error("miss answered");
  a_drive_on_read: assert property (bus_rdata_oe_o |-> $past(bus_req_i.rd && hit))
    else $error("data driven");
  a_one_ser_sel: assert property (|per_sel_o.ser_cs |-> $onehot(per_sel_o.ser_cs) && !per_sel_o.clk_cs && !$past(p[2]))
    else $error("serial select");
  a_clk_sel_port: assert property (per_sel_o.clk_cs |-> $past(p) == PORT_CLK_DATA)
    else $error("clock select");
  a_wait_has_strobe: assert property ($fell(bus_ready_o) |-> per_rd_o || per_wr_o)
    else $error("wait without strobe");
  c_serial: cover property (st && !p[2]);
  c_clock: cover property (st && p == PORT_CLK_DATA);
  c_miss: cover property (bus_req_i.rd && !hit);
endmodule
bind iopdw_glue iopdw_monitor u_mon (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .long_addr_i(long_addr_i),
  .bus_ready_o(bus_ready_o), .bus_rdata_oe_o(bus_rdata_oe_o), .per_rd_o(per_rd_o), .per_wr_o(per_wr_o),
  .base_sw_i(base_sw_i), .bus_req_i(bus_req_i), .per_sel_o(per_sel_o));

// ==== dv/iopdw_periph_model.sv ====
// far-side model: serial controller banks and indexed clock registers
`timescale 1ns/100ps
module iopdw_periph_model import iopdw_pkg::*; (
  input wire logic clk_i, rd_i, wr_i,
  input wire iopdw_sel_type sel_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] ser_m [16]; // four controllers, four registers each
  logic [7:0] clk_m [32]; // indexed clock registers
  logic [7:0] pat_r = 8'h5A; // released bus toggles so a stale byte never passes
  wire [1:0] bank = {sel_i.ser_cs[3] | sel_i.ser_cs[2], sel_i.ser_cs[3] | sel_i.ser_cs[1]};
  wire ser = |sel_i.ser_cs;
  assign rdata_o = !rd_i ? pat_r : ser ? ser_m[{bank, sel_i.ser_reg}] : clk_m[sel_i.clk_idx];
  always_ff @(posedge clk_i) begin
    pat_r <= ~pat_r;
    if (wr_i && ser) ser_m[{bank, sel_i.ser_reg}] <= wdata_i;
    if (wr_i && sel_i.clk_cs) clk_m[sel_i.clk_idx] <= wdata_i;
  end
endmodule

// ==== dv/testbench.sv ====
// bench: register map, wait counts, decode and interrupt routing against a reference model
`timescale 1ns/100ps
module testbench import iopdw_pkg::*;;
  logic clk = 0, rst = 1, lng = 0, stb = 0, gen = 0, oe, rdy, prd, pwr;
  logic [12:0] bsw = 0;
  logic [7:0] usw = 0, sirq = 0, rdat, pwd, pdat;
  logic [3:0] sr = 0, sg = 0, gr = 0;
  logic [8:0] irq;
  iopdw_req_type req = '0;
  iopdw_sel_type sel;
  int unsigned seed = 79226;
  int bank, idx, errors, tests_run;
  logic [7:0] ser_m [16], clk_m [32];
  iopdw_glue u_dut (.core_clk_i(clk), .sys_rst_i(rst), .bus_req_i(req), .bus_rdata_o(rdat), .bus_rdata_oe_o(oe),
    .bus_ready_o(rdy), .base_sw_i(bsw), .long_addr_i(lng), .user_sw_i(usw), .per_sel_o(sel), .per_rd_o(prd),
    .per_wr_o(pwr), .per_wdata_o(pwd), .per_rdata_i(pdat), .ser_irq_i(sirq), .clk_stby_irq_i(stb),
    .clk_gen_irq_i(gen), .ser_irq_route_i(sr), .stby_irq_route_i(sg), .gen_irq_route_i(gr), .bus_irq_o(irq));
  iopdw_periph_model u_per (.clk_i(clk), .rd_i(prd), .wr_i(pwr), .sel_i(sel), .wdata_i(pwd), .rdata_o(pdat));
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [8:0] e, logic [8:0] s);
    tests_run++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      errors++;
    end
  endtask
  // one bus cycle; a miss flips the lowest compared address bit
  task automatic acc(int p, bit w, bit hit, logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    req.addr <= lng ? {bsw ^ 13'(!hit), 3'(p)} : {8'(rnd()), bsw[4:0] ^ 5'(!hit), 3'(p)};
    req.wdata <= d;
    req.rd <= !w;
    req.wr <= w;
    repeat (9) begin
      @(posedge clk);
      #1;
      if (rdy === 1'b1) break;
      n++;
    end
    if (n == 9) begin
      errors++;
      report_and_stop();
    end
    q = rdat;
    chk("waits", !hit ? 0 : p < 4 ? 2 : p == 6 ? 4 : 0, n);
    chk("drive", !w && hit, oe);
    @(posedge clk);
    req.rd <= 0;
    req.wr <= 0;
    @(posedge clk);
  endtask
  task automatic run_mode(bit m);
    logic [7:0] q, v;
    logic [8:0] e;
    @(posedge clk);
    rst <= 1;
    lng <= m;
    bsw <= 13'(rnd());
    repeat (10) @(posedge clk);
    rst <= 0;
    bank = 0;
    acc(5, 0, 1, 0, q);
    chk("index_reset", 0, q);
    for (int b = 3; b >= 0; b--) begin
      acc(4, 1, 1, 8'(b), q);
      for (int p = 0; p < 4; p++) begin
        v = 8'(rnd());
        acc(p, 1, 1, v, q);
        ser_m[b * 4 + p] = v;
      end
      idx = b == 3 ? 31 : b * 9;
      acc(5, 1, 1, 8'(idx), q);
      v = 8'(rnd());
      acc(6, 1, 1, v, q);
      clk_m[idx] = v;
    end
    for (int b = 0; b < 4; b++) begin
      acc(4, 1, 1, 8'(b), q);
      bank = b;
      for (int p = 0; p < 4; p++) begin
        acc(p, 0, 1, 0, q);
        chk("serial", ser_m[b * 4 + p], q);
      end
      idx = b == 3 ? 31 : b * 9;
      acc(5, 1, 1, 8'(idx), q);
      acc(6, 0, 1, 0, q);
      chk("clock", clk_m[idx], q);
      acc(5, 0, 1, 0, q);
      chk("index", {bank[1:0], 1'b0, idx[4:0]}, q);
    end
    usw <= 8'(rnd());
    repeat (4) @(posedge clk);
    acc(7, 0, 1, 0, q);
    chk("switch", usw, q);
    acc(0, 0, 0, 0, q);
    acc(4, 1, 0, 8'h00, q);
    acc(0, 0, 1, 0, q);
    chk("miss", ser_m[bank * 4], q);
    repeat (8) begin
      @(posedge clk);
      {sirq, stb, gen, sr, sg, gr} <= 22'(rnd());
      repeat (3) @(posedge clk);
      #1;
      e = 0;
      if (|sirq && sr < 9) e[sr] = 1;
      if (stb && sg < 9) e[sg] = 1;
      if (gen && gr < 9) e[gr] = 1;
      chk("irq", e, irq);
    end
    $display("mode %0d done", m);
  endtask
  initial forever #50 clk = ~clk;
  initial begin
    run_mode(0);
    run_mode(1);
    report_and_stop();
  end
endmodule
